/* hdl/issr_defs.svh */
/*
  Constants of the inertial sensor serial readout: frame layout, register
  window, link timing and sample timing, as text macros.
  Assumes a 50 MHz system clock on both ends.
*/
`ifndef ISSR_DEFS_SVH
`define ISSR_DEFS_SVH

// Frame layout
`define ISSR_WORD_W 16
`define ISSR_RW_BIT 15
`define ISSR_ADDR_HI 14
`define ISSR_ADDR_LO 8
`define ISSR_LAST_BIT 4'hf
`define ISSR_BURST_CMD 16'h3e00

// Output register window
`define ISSR_REG_COUNT 8
`define ISSR_IDX_W 3
`define ISSR_LAST_IDX 3'h7
`define ISSR_FIRST_ADDR 7'h04
`define ISSR_LAST_ADDR 7'h12

// Times as printed
`define ISSR_CLK_NS 20
`define ISSR_SAMPLE_SPS 1024
`define ISSR_STARTUP_MS 210
`define ISSR_SCLK_NORM_KHZ 2000
`define ISSR_SCLK_BURST_KHZ 1000
`define ISSR_T_CS_PS 48800
`define ISSR_T_STALL_NS 9000
`define ISSR_T_RATE_NS 40000
`define ISSR_T_DONE_NS 200

// Derived cycle counts
`define ISSR_SAMPLE_CYC (1000000000 / (`ISSR_CLK_NS * `ISSR_SAMPLE_SPS))
`define ISSR_STARTUP_CYC (`ISSR_STARTUP_MS * 1000000 / `ISSR_CLK_NS)
`define ISSR_HALF_CYC(k) ((1000000 / (2 * (k)) + `ISSR_CLK_NS - 1) / `ISSR_CLK_NS)
`define ISSR_CS_CYC ((`ISSR_T_CS_PS + `ISSR_CLK_NS * 1000 - 1) / (`ISSR_CLK_NS * 1000))
`define ISSR_STALL_CYC ((`ISSR_T_STALL_NS + `ISSR_CLK_NS - 1) / `ISSR_CLK_NS)
`define ISSR_RATE_CYC ((`ISSR_T_RATE_NS + `ISSR_CLK_NS - 1) / `ISSR_CLK_NS)
`define ISSR_DONE_CYC ((`ISSR_T_DONE_NS + `ISSR_CLK_NS - 1) / `ISSR_CLK_NS)

`endif

/* hdl/issr_pkg.sv */
/*
  Types shared by both ends of the inertial sensor serial readout.
  Assumes issr_defs.svh is on the include path.
*/
`include "issr_defs.svh"

package issr_pkg;

  typedef logic [`ISSR_WORD_W-1:0] issr_word_t;
  typedef logic [`ISSR_REG_COUNT-1:0][`ISSR_WORD_W-1:0] issr_bank_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_SETUP = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b011,
    M_GAP = 3'b100,
    M_STALL = 3'b101
  } issr_mst_state_t;

endpackage : issr_pkg

/* hdl/issr_link_if.sv */
/*
  Serial link between the sensor end and the master end.
  Assumes the bench resolves nothing: every wire has one driver.
*/
`timescale 1ns/1ps

interface issr_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic sample_done_pin;

  modport dev (
    input sclk,
    input cs_n,
    input mosi,
    output miso,
    output sample_done_pin
  );

  modport mst (
    output sclk,
    output cs_n,
    output mosi,
    input miso,
    input sample_done_pin
  );
endinterface : issr_link_if

/* hdl/issr_sensor.sv */
/*
  Sensor end: autonomous sampler on the system clock, serial slave on the
  link clock (sclk, made by the master).
  Assumes the master keeps mode 3, frame and stall timing of the link.
*/
`timescale 1ns/1ps

`include "issr_defs.svh"

// Behaviour
// - Self start, then sample at 1024 per second
// - Pulse sample-done high after every sample
// - Shift data-out on falling serial clock edge
// - Sample data-in on rising serial clock edge
// - Master runs mode 3, clock idles high
// - Sixteen-bit frames, most significant bit first
// - Ordinary access serial clock at most 2 MHz
// - Burst serial clock at most 1 MHz
// - Sensor is slave, never drives clock/select
// - Read takes request frame, then data frame
// - Low byte of read request ignored
// - Zero top flag, address in upper byte
// - Full duplex: answer old, accept new request
// - Data-out is register named by previous read
// - After a write, master discards data-out
// - Burst starts with command word 0x3E00
// - Burst returns output registers ascending order
// - Burst gap may shrink to one period
// - Sync pin is general input or sync clock
// - Master keeps 9 us stall, 40 us period
// - Write frame: flag one, address, data byte
// - Output registers at even addresses 0x04-0x12
module issr_sensor #(
  parameter int STARTUP_CYCLES = `ISSR_STARTUP_CYC,
  parameter int SAMPLE_CYCLES = `ISSR_SAMPLE_CYC,
  parameter int DONE_CYCLES = `ISSR_DONE_CYC
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link, sensor side
  issr_link_if.dev link,
  // Sensor results
  input wire issr_pkg::issr_bank_t sensor_data,
  // Sync pin configuration
  input wire logic sync_mode,
  input wire logic sync_clock_pin,
  // Status
  output logic gpio_level,
  output logic running
);
  import issr_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic issr_addr_ok(input logic [6:0] addr);
    issr_addr_ok = !addr[0] && (addr >= `ISSR_FIRST_ADDR) &&
                   (addr <= `ISSR_LAST_ADDR);
  endfunction : issr_addr_ok

  function automatic logic [`ISSR_IDX_W-1:0] issr_addr_index(
    input logic [6:0] addr
  );
    logic [6:0] offset;
    offset = addr - `ISSR_FIRST_ADDR;
    issr_addr_index = offset[`ISSR_IDX_W:1];
  endfunction : issr_addr_index

  //////////////////////////////////////////////////////////////////////////
  // System domain: start-up and sample timing

  logic [23:0] start_cnt;
  logic [15:0] sample_cnt;
  logic [7:0] done_cnt;
  logic sync_meta;
  logic sync_s2;
  logic sync_s3;
  logic cs_meta;
  logic cs_idle;
  logic link_clear;
  logic sample_done;
  issr_bank_t sensor_reg;
  issr_bank_t link_reg;

  wire sync_rise = sync_s2 && !sync_s3;
  wire timer_hit = (sample_cnt == 16'h0000);
  wire sample_evt = running && (sync_mode ? sync_rise : timer_hit);
  wire start_done = (start_cnt == 24'(STARTUP_CYCLES - 1));

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      start_cnt <= 24'h000000;
      running <= 1'b0;
    end
    else if (!running)
    begin
      start_cnt <= start_cnt + 24'h000001;
      running <= start_done;
    end
  end

  // Sample period countdown, restarted on each sample; holds at zero in sync mode
  always_ff @(posedge clock)
  begin
    if (rst || !running || sample_evt)
      sample_cnt <= 16'(SAMPLE_CYCLES - 1);
    else if (!timer_hit)
      sample_cnt <= sample_cnt - 16'h0001;
  end

  // Sync pin: two stages, then a third only for edge detection
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_meta <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      gpio_level <= 1'b0;
    end
    else
    begin
      sync_meta <= sync_clock_pin;
      sync_s2 <= sync_meta;
      sync_s3 <= sync_s2;
      gpio_level <= sync_mode ? 1'b0 : sync_s2;
    end
  end

  // Results land and sample-done rises at the same edge, for a short fixed pulse
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sensor_reg <= '0;
      done_cnt <= 8'h00;
      sample_done <= 1'b0;
    end
    else
    begin
      if (sample_evt)
        sensor_reg <= sensor_data;
      if (sample_evt)
        done_cnt <= 8'(DONE_CYCLES);
      else if (done_cnt != 8'h00)
        done_cnt <= done_cnt - 8'h01;
      sample_done <= sample_evt || (done_cnt > 8'h01);
    end
  end

  assign link.sample_done_pin = sample_done;

  //////////////////////////////////////////////////////////////////////////
  // Crossing: link copy frozen while select is low

  // The link domain reads link_reg only inside a frame; it changes only
  // while select is seen high. Limitation: a sample landing within two
  // system clocks of the select falling edge can race the first bit.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cs_meta <= 1'b1;
      cs_idle <= 1'b1;
      link_clear <= 1'b1;
    end
    else
    begin
      cs_meta <= link.cs_n;
      cs_idle <= cs_meta;
      link_clear <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `ISSR_REG_COUNT; gi++)
    begin : g_copy
      always_ff @(posedge clock)
      begin
        if (rst)
          link_reg[gi] <= '0;
        else if (cs_idle)
          link_reg[gi] <= sensor_reg[gi];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Link domain: slave shifter on sclk

  logic [3:0] bit_cnt;
  logic [`ISSR_WORD_W-2:0] rx;
  issr_word_t tx;
  logic burst;
  logic [`ISSR_IDX_W-1:0] burst_idx;
  logic sel_valid;
  logic [`ISSR_IDX_W-1:0] sel_index;

  // Sclk and select are inputs only: the master owns the clock
  wire [`ISSR_WORD_W-1:0] rx_word = {rx, link.mosi};
  wire frame_end = (bit_cnt == `ISSR_LAST_BIT);
  wire [6:0] req_addr = rx_word[`ISSR_ADDR_HI:`ISSR_ADDR_LO];
  wire req_read = !rx_word[`ISSR_RW_BIT];
  wire req_burst = (rx_word == `ISSR_BURST_CMD);
  wire [`ISSR_IDX_W-1:0] out_idx = burst ? burst_idx : sel_index;
  wire out_valid = burst || sel_valid;
  wire [`ISSR_WORD_W-1:0] load_word = out_valid ? link_reg[out_idx] : '0;

  // Frame position, cleared by select high (constant under reset)
  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
      bit_cnt <= 4'h0;
    else
      bit_cnt <= bit_cnt + 4'h1;
  end

  always_ff @(posedge link.sclk or posedge link_clear)
  begin
    if (link_clear)
      rx <= '0;
    else
      rx <= rx_word[`ISSR_WORD_W-2:0];
  end

  // Request decode at the sixteenth rising edge
  always_ff @(posedge link.sclk or posedge link_clear)
  begin
    if (link_clear)
    begin
      burst <= 1'b0;
      burst_idx <= '0;
      sel_valid <= 1'b0;
      sel_index <= '0;
    end
    else if (frame_end)
    begin
      if (burst)
      begin
        burst_idx <= burst_idx + 3'h1;
        burst <= (burst_idx != `ISSR_LAST_IDX);
        sel_valid <= 1'b0;
      end
      else if (req_burst)
      begin
        burst <= 1'b1;
        burst_idx <= '0;
      end
      else
      begin
        // Writes leave data-out at zero for the next frame
        sel_valid <= req_read && issr_addr_ok(req_addr);
        sel_index <= issr_addr_index(req_addr);
      end
    end
  end

  // Mode 3: first edge of a frame is falling, so load there
  always_ff @(negedge link.sclk or posedge link_clear)
  begin
    if (link_clear)
      tx <= '0;
    else if (bit_cnt == 4'h0)
      tx <= load_word;
    else
      tx <= {tx[`ISSR_WORD_W-2:0], 1'b0};
  end

  assign link.miso = tx[`ISSR_WORD_W-1];

endmodule : issr_sensor

/* hdl/issr_master.sv */
/*
  Master end: makes sclk by dividing the system clock, runs mode 3 frames,
  single reads/writes and burst reads, and keeps the stall timing.
  Assumes a user that presents one command at a time with valid/ready.
*/
`timescale 1ns/1ps

`include "issr_defs.svh"

module issr_master #(
  parameter int NORM_HALF_CYCLES = `ISSR_HALF_CYC(`ISSR_SCLK_NORM_KHZ),
  parameter int BURST_HALF_CYCLES = `ISSR_HALF_CYC(`ISSR_SCLK_BURST_KHZ),
  parameter int SEL_CYCLES = `ISSR_CS_CYC,
  parameter int STALL_CYCLES = `ISSR_STALL_CYC,
  parameter int RATE_CYCLES = `ISSR_RATE_CYC
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link, master side
  issr_link_if.mst link,
  // Command
  input wire logic cmd_valid,
  input wire logic cmd_burst,
  input wire issr_pkg::issr_word_t cmd_word,
  output logic cmd_ready,
  // Answer
  output logic resp_valid,
  output issr_pkg::issr_word_t resp_word,
  output logic [3:0] resp_index,
  output logic new_sample
);
  import issr_pkg::*;

  issr_mst_state_t state;
  logic [11:0] tick;
  logic [11:0] rate;
  logic [3:0] bit_cnt;
  logic [3:0] seg;
  logic in_burst;
  issr_word_t tx;
  logic [`ISSR_WORD_W-1:0] rx;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso_meta;
  logic miso_s;
  logic done_meta;
  logic done_s2;
  logic done_s3;

  //////////////////////////////////////////////////////////////////////////
  // Timing selection

  // Burst runs the slower clock for the whole frame
  wire [11:0] half = in_burst ? 12'(BURST_HALF_CYCLES) : 12'(NORM_HALF_CYCLES);
  wire tick_done = (tick == 12'h000);
  wire last_bit = (bit_cnt == `ISSR_LAST_BIT);
  wire more_seg = in_burst && (seg != 4'(`ISSR_REG_COUNT));

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = mosi;

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
      done_meta <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      new_sample <= 1'b0;
    end
    else
    begin
      miso_meta <= link.miso;
      miso_s <= miso_meta;
      done_meta <= link.sample_done_pin;
      done_s2 <= done_meta;
      done_s3 <= done_s2;
      new_sample <= done_s2 && !done_s3;
    end
  end

  // Start-to-start spacing, counted from each frame's select fall
  always_ff @(posedge clock)
  begin
    if (rst)
      rate <= 12'h000;
    else if (state == M_IDLE && cmd_valid)
      rate <= 12'(RATE_CYCLES - 1);
    else if (rate != 12'h000)
      rate <= rate - 12'h001;
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame sequencer

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= M_IDLE;
      tick <= 12'h000;
      bit_cnt <= 4'h0;
      seg <= 4'h0;
      in_burst <= 1'b0;
      tx <= '0;
      rx <= '0;
      sclk <= 1'b1;
      cs_n <= 1'b1;
      mosi <= 1'b0;
      cmd_ready <= 1'b1;
      resp_valid <= 1'b0;
      resp_word <= '0;
      resp_index <= 4'h0;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (!tick_done)
        tick <= tick - 12'h001;
      case (state)
        M_IDLE:
        begin
          if (cmd_valid)
          begin
            // Burst always sends the burst command word
            tx <= cmd_burst ? `ISSR_BURST_CMD : cmd_word;
            in_burst <= cmd_burst;
            cs_n <= 1'b0;
            cmd_ready <= 1'b0;
            seg <= 4'h0;
            bit_cnt <= 4'h0;
            tick <= 12'(SEL_CYCLES - 1);
            state <= M_SETUP;
          end
        end
        M_SETUP:
        begin
          if (tick_done)
          begin
            sclk <= 1'b0;
            mosi <= tx[`ISSR_WORD_W-1];
            tick <= half - 12'h001;
            state <= M_LOW;
          end
        end
        M_LOW:
        begin
          if (tick_done)
          begin
            sclk <= 1'b1;
            rx <= {rx[`ISSR_WORD_W-2:0], miso_s};
            tick <= half - 12'h001;
            state <= M_HIGH;
          end
        end
        M_HIGH:
        begin
          if (tick_done && last_bit)
          begin
            resp_valid <= 1'b1;
            resp_word <= rx;
            resp_index <= seg;
            if (more_seg)
            begin
              seg <= seg + 4'h1;
              bit_cnt <= 4'h0;
              tx <= '0;
              tick <= {half[10:0], 1'b0} - 12'h001;
              state <= M_GAP;
            end
            else
            begin
              cs_n <= 1'b1;
              tick <= 12'(STALL_CYCLES - 1);
              state <= M_STALL;
            end
          end
          else if (tick_done)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            sclk <= 1'b0;
            mosi <= tx[`ISSR_WORD_W-2];
            tx <= {tx[`ISSR_WORD_W-2:0], 1'b0};
            tick <= half - 12'h001;
            state <= M_LOW;
          end
        end
        M_GAP:
        begin
          if (tick_done)
          begin
            sclk <= 1'b0;
            mosi <= 1'b0;
            tick <= half - 12'h001;
            state <= M_LOW;
          end
        end
        M_STALL:
        begin
          if (tick_done && rate == 12'h000)
          begin
            in_burst <= 1'b0;
            cmd_ready <= 1'b1;
            state <= M_IDLE;
          end
        end
        default:
        begin
          state <= M_IDLE;
        end
      endcase
    end
  end

endmodule : issr_master

/* verification/issr_checker.sv */
/*
  Checker for the serial link between sensor end and master end.
  Assumes one system clock for both ends and sclk made from it by the master.
*/
`timescale 1ns/1ps

module issr_checker #(
  parameter int SAMPLE_CYCLES = 200,
  parameter int STALL_CYCLES = 20,
  parameter int RATE_CYCLES = 60
) (
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sample_done_pin,
  // Sync pin configuration
  input wire logic sync_mode
);
  logic sclk_q;
  logic [15:0] rise_cnt;
  logic [15:0] half_cnt;
  logic [15:0] high_cnt;
  logic cs_q;
  logic [15:0] idle_cnt;
  logic [15:0] start_gap;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Helper counters; half_cnt starts large so the first edge is not flagged
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sclk_q <= 1'b1;
      rise_cnt <= 16'h0000;
      half_cnt <= 16'h0100;
      high_cnt <= 16'h0000;
      cs_q <= 1'b1;
      idle_cnt <= 16'hffff;
      start_gap <= 16'hffff;
    end
    else
    begin
      // Spacing counters saturate so a long idle never wraps
      cs_q <= cs_n;
      idle_cnt <= !cs_n ? 16'h0000 : (idle_cnt == 16'hffff) ? idle_cnt : idle_cnt + 16'h0001;
      start_gap <= (cs_q && !cs_n) ? 16'h0001 :
        (start_gap == 16'hffff) ? start_gap : start_gap + 16'h0001;
      sclk_q <= sclk;
      rise_cnt <= cs_n ? 16'h0000 : rise_cnt + {15'h0000, sclk & ~sclk_q};
      half_cnt <= (sclk != sclk_q) ? 16'h0001 : half_cnt + 16'h0001;
      high_cnt <= (sclk && !cs_n) ? high_cnt + 16'h0001 : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_sample_rate;
    @(posedge clock) disable iff (rst || sync_mode)
    $rose(sample_done_pin) |-> ##SAMPLE_CYCLES $rose(sample_done_pin);
  endproperty
  a_sample_rate: assert property (p_sample_rate) else $error("sample period wrong");

  property p_done_pulse;
    $rose(sample_done_pin) |-> sample_done_pin[*8] ##1 sample_done_pin ##1 sample_done_pin
      ##1 !sample_done_pin;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse width wrong");

  property p_miso_on_fall;
    $changed(miso) |-> $fell(sclk);
  endproperty
  a_miso_on_fall: assert property (p_miso_on_fall) else $error("miso moved off falling edge");

  property p_mosi_stable;
    $rose(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved at rising edge");

  property p_idle_high;
    cs_n |-> sclk;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("sclk low while deselected");

  property p_frame_bits;
    $rose(cs_n) |-> (rise_cnt == 16'h0010) || (rise_cnt == 16'h0090);
  endproperty
  a_frame_bits: assert property (p_frame_bits) else $error("frame bit count wrong");

  property p_half_period;
    $changed(sclk) && !cs_n |-> half_cnt >= 16'h000d;
  endproperty
  a_half_period: assert property (p_half_period) else $error("sclk half period short");

  property p_burst_half;
    $changed(sclk) && !cs_n && (rise_cnt >= 16'h0010) |-> half_cnt >= 16'h0019;
  endproperty
  a_burst_half: assert property (p_burst_half) else $error("burst sclk half period short");

  property p_frame_spacing;
    $fell(cs_n) |-> (idle_cnt >= 16'(STALL_CYCLES)) && (start_gap >= 16'(RATE_CYCLES));
  endproperty
  a_frame_spacing: assert property (p_frame_spacing) else $error("frames too close");

  property p_burst_gap;
    high_cnt <= 16'h0050;
  endproperty
  a_burst_gap: assert property (p_burst_gap) else $error("sclk gap too long");

  property p_select_lead;
    $fell(cs_n) |-> sclk[*3];
  endproperty
  a_select_lead: assert property (p_select_lead) else $error("sclk fell too soon");

  c_frame: cover property ($rose(cs_n) && rise_cnt == 16'h0010);
  c_burst: cover property ($rose(cs_n) && rise_cnt == 16'h0090);
  c_sample: cover property ($rose(sample_done_pin));
endmodule : issr_checker

/* verification/test_imu_spi_sensor_readout.sv */
/*
  Testbench joining sensor end and master end across the link interface.
  Assumes both ends share the bench clock; counts are shortened for speed.
*/
`timescale 1ns/1ps

module test_imu_spi_sensor_readout;
  import issr_pkg::*;
  localparam int SAMPLE = 200;
  localparam logic [15:0] REQS [14] = '{16'h0400, 16'h0600, 16'h0800, 16'h0a00, 16'h0c00,
    16'h0e00, 16'h1000, 16'h1200, 16'h0500, 16'h0200, 16'h1400, 16'hb703, 16'h0e00, 16'h1200};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_burst = 1'b0;
  issr_word_t cmd_word = 16'h0000;
  logic cmd_ready;
  logic resp_valid;
  issr_word_t resp_word;
  logic [3:0] resp_index;
  logic new_sample;
  logic sync_mode = 1'b0;
  logic sync_clock_pin = 1'b0;
  logic gpio_level;
  logic running;
  issr_bank_t bank = '0;
  issr_word_t got [9];
  issr_word_t req;
  issr_word_t prev;
  logic [31:0] seed = 32'h5fe7;
  int cycles = 0;
  int sample_count = 0;
  int s0;
  int mismatches = 0;
  int check_count = 0;

  issr_link_if issr_link_if_inst ();

  issr_sensor #(.STARTUP_CYCLES(20), .SAMPLE_CYCLES(SAMPLE), .DONE_CYCLES(10)) issr_sensor_inst (
    .clock(clock), .rst(rst), .link(issr_link_if_inst), .sensor_data(bank),
    .sync_mode(sync_mode), .sync_clock_pin(sync_clock_pin), .gpio_level(gpio_level),
    .running(running));

  issr_master #(.STALL_CYCLES(20), .RATE_CYCLES(60)) issr_master_inst (
    .clock(clock), .rst(rst), .link(issr_link_if_inst), .cmd_valid(cmd_valid),
    .cmd_burst(cmd_burst), .cmd_word(cmd_word), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_word(resp_word), .resp_index(resp_index), .new_sample(new_sample));

  issr_checker #(.SAMPLE_CYCLES(SAMPLE), .STALL_CYCLES(20), .RATE_CYCLES(60)) issr_checker_inst (
    .clock(clock), .rst(rst), .sclk(issr_link_if_inst.sclk), .cs_n(issr_link_if_inst.cs_n),
    .mosi(issr_link_if_inst.mosi), .miso(issr_link_if_inst.miso),
    .sample_done_pin(issr_link_if_inst.sample_done_pin), .sync_mode(sync_mode));

  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd

  // Refused reads answer zero, so only even window addresses carry data
  function automatic issr_word_t expect_word(input issr_word_t r, input issr_bank_t b);
    logic [6:0] a;
    a = r[14:8];
    if (r[15] || a[0] || a < 7'h04 || a > 7'h12)
      return 16'h0000;
    return b[(a - 7'h04) >> 1];
  endfunction : expect_word

  task automatic cmp_word(input string what, input issr_word_t exp, input issr_word_t seen);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string what, input logic exp, input logic seen);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Entered at a falling edge; collects segs answer segments
  task automatic transfer(input logic burst, input issr_word_t word, input int segs);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1)
      @(negedge clock);
    cmd_valid = 1'b1;
    cmd_burst = burst;
    cmd_word = word;
    @(negedge clock);
    cmd_valid = 1'b0;
    while (n < segs)
    begin
      @(negedge clock);
      if (resp_valid === 1'b1)
      begin
        got[n] = resp_word;
        cmp_word("segment index", 16'(n), {12'h000, resp_index});
        n++;
      end
    end
  endtask : transfer

  always @(posedge clock)
  begin
    cycles++;
    if (new_sample === 1'b1)
      sample_count++;
    if (cycles == 40000)
    begin
      mismatches++;
      $display("unexpected cycles: expected below %0d, seen %0d", 40000, cycles);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    repeat (10) @(negedge clock);
    cmp_bit("running early", 1'b0, running);
    repeat (20) @(negedge clock);
    cmp_bit("running", 1'b1, running);
    for (int i = 0; i < 8; i++)
      bank[i] = rnd();
    bank[0] = 16'h8000;
    bank[7] = 16'h0001;
    repeat (SAMPLE + 60) @(negedge clock);
    prev = 16'hffff;
    for (int i = 0; i < 14; i++)
    begin
      req = REQS[i];
      if (!req[15])
        req[7:0] = 8'(rnd());
      transfer(1'b0, req, 1);
      if (!prev[15])
        cmp_word("read data", expect_word(prev, bank), got[0]);
      prev = req;
    end
    transfer(1'b1, 16'h0000, 9);
    cmp_word("burst head", expect_word(prev, bank), got[0]);
    for (int k = 1; k < 9; k++)
      cmp_word("burst data", bank[k-1], got[k]);
    transfer(1'b0, 16'h0600, 1);
    cmp_word("after burst", 16'h0000, got[0]);
    transfer(1'b0, 16'h0000, 1);
    cmp_word("read after burst", bank[1], got[0]);
    s0 = sample_count;
    repeat (10 * SAMPLE) @(negedge clock);
    cmp_word("sample count", 16'h000a, 16'(sample_count - s0));
    for (int i = 0; i < 4; i++)
    begin
      sync_clock_pin = rnd() > 16'h7fff;
      repeat (6) @(negedge clock);
      cmp_bit("gpio level", sync_clock_pin, gpio_level);
    end
    sync_clock_pin = 1'b0;
    sync_mode = 1'b1;
    repeat (6) @(negedge clock);
    cmp_bit("gpio in sync mode", 1'b0, gpio_level);
    s0 = sample_count;
    repeat (3)
    begin
      sync_clock_pin = 1'b1;
      repeat (20) @(negedge clock);
      sync_clock_pin = 1'b0;
      repeat (20) @(negedge clock);
    end
    cmp_word("sync samples", 16'h0003, 16'(sample_count - s0));
    end_of_test();
  end
endmodule : test_imu_spi_sensor_readout
